// File: shared/fbp_pkg.sv
// Package for the four-bit port: register map, field layout and reset values.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
package fbp_pkg;
  localparam int          ADDR_W           = 4;
  localparam int          PORT_W           = 4;
  localparam int          ANA_W            = 3;
  localparam int          PIN3             = 3;
  localparam int          REG_W            = 8;
  localparam logic [3:0]  OFF_PIN_DATA     = 4'h0;
  localparam logic [3:0]  OFF_DIRECTION    = 4'h4;
  localparam logic [3:0]  OFF_ANALOG_SEL   = 4'h8;
  localparam logic [3:0]  OFF_CONFIG       = 4'hC;
  localparam logic [3:0]  DIR_RESET        = 4'hF;
  localparam logic [2:0]  ANA_RESET        = 3'h7;
  localparam logic [2:0]  LATCH_RESET      = 3'h0;
  localparam logic        MASTER_CLEAR_ENABLE_CFG_RESET      = 1'b1;
  localparam int          CFG_MASTER_CLEAR_ENABLE_CFG_BIT    = 0;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  localparam logic [1:0]  SYNC_RESET       = 2'h0;
endpackage : fbp_pkg

// File: core/fbp_sync.sv
// Two-flop synchroniser for a vector of pin levels.
// Assumes inputs are asynchronous to CLOCK_I.
`timescale 1ns/1ps
module fbp_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : fbp_sync

// File: core/fbp_port.sv
// Four-bit general purpose port with analog select and input-only pin 3.
// Assumes an AXI4-Lite master on CLOCK_I and pad cells that resolve the pins.
`timescale 1ns/1ps
module fbp_port #(
  parameter bit HAS_LOWER_PINS = 1'b1
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic [3:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [3:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  input  wire logic [3:0]  PIN_I,
  output logic [2:0]       PIN_O,
  output logic [2:0]       PIN_OE_N_O,
  output logic             PIN3_PULLUP_EN_O,
  output logic             MASTER_CLEAR_N_O
);
  localparam logic [2:0] LOWER_MASK = HAS_LOWER_PINS ? 3'h7 : 3'h0;
  localparam int         SEL_DATA   = 0;
  localparam int         SEL_DIR    = 1;
  localparam int         SEL_ANA    = 2;
  localparam int         SEL_CFG    = 3;

  logic [3:0]  pin_sync;
  logic [2:0]  latch;
  logic [2:0]  dir_low;
  logic [2:0]  ana_sel;
  logic        master_clear_enable_cfg;
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [7:0]  w_byte;
  logic        w_lane0;
  logic [3:0]  pin_view;
  logic [3:0]  dir_view;
  logic        do_write;
  logic [2:0]  next_latch;
  logic [3:0]  wr_sel;
  logic [3:0]  wr_en;

  // Pin levels pass two flops before any read path sees them
  fbp_sync #(.WIDTH(fbp_pkg::PORT_W)) u_sync (
    .clk_i   (CLOCK_I),
    .rst_n_i (RST_N_I),
    .d_i     (PIN_I),
    .q_o     (pin_sync)
  );

  function automatic logic [31:0] fbp_zext(input logic [7:0] v);
    fbp_zext = {24'h000000, v};
  endfunction : fbp_zext

  // One-hot register select; an unmapped address selects nothing
  function automatic logic [3:0] fbp_decode(input logic [3:0] addr);
    fbp_decode = 4'h0;
    case (addr)
      fbp_pkg::OFF_PIN_DATA:   fbp_decode[SEL_DATA] = 1'b1;
      fbp_pkg::OFF_DIRECTION:  fbp_decode[SEL_DIR]  = 1'b1;
      fbp_pkg::OFF_ANALOG_SEL: fbp_decode[SEL_ANA]  = 1'b1;
      fbp_pkg::OFF_CONFIG:     fbp_decode[SEL_CFG]  = 1'b1;
      default:                 fbp_decode           = 4'h0;
    endcase
  endfunction : fbp_decode

  // Per lower pin: digital view masked by analog select, and a driver that
  // follows direction only, so analog select never gates an output
  for (genvar g = 0; g < fbp_pkg::ANA_W; g++) begin : g_lower_pin
    assign pin_view[g]   = pin_sync[g] & ~ana_sel[g] & LOWER_MASK[g];
    assign PIN_OE_N_O[g] = dir_low[g] | ~LOWER_MASK[g];
    assign PIN_O[g]      = latch[g] & LOWER_MASK[g];
  end

  // Pin 3 has no driver; master clear enable hides its level from reads
  assign pin_view[fbp_pkg::PIN3] = pin_sync[fbp_pkg::PIN3] & ~master_clear_enable_cfg;

  assign dir_view = {1'b1, dir_low & LOWER_MASK};
  assign PIN3_PULLUP_EN_O = master_clear_enable_cfg;
  assign MASTER_CLEAR_N_O = master_clear_enable_cfg ? pin_sync[fbp_pkg::PIN3] : 1'b1;

  // Write channel: address and data accepted independently, in either order
  assign AWREADY_O = !aw_held && !BVALID_O;
  assign WREADY_O  = !w_held && !BVALID_O;
  assign do_write  = aw_held && w_held && !BVALID_O;
  assign wr_sel    = fbp_decode(aw_addr);
  // A cleared low strobe lane still answers, but changes no register
  assign wr_en     = (do_write && w_lane0) ? wr_sel : 4'h0;

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (AWVALID_I && AWREADY_O) begin
      aw_held <= 1'b1;
      aw_addr <= AWADDR_I;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (WVALID_I && WREADY_O) begin
      w_held  <= 1'b1;
      w_byte  <= WDATA_I[7:0];
      w_lane0 <= WSTRB_I[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BVALID_O <= 1'b0;
      BRESP_O  <= fbp_pkg::RESP_OKAY;
    end else if (do_write) begin
      BVALID_O <= 1'b1;
      BRESP_O  <= (|wr_sel) ? fbp_pkg::RESP_OKAY : fbp_pkg::RESP_SLVERR;
    end else if (BREADY_I) begin
      BVALID_O <= 1'b0;
    end
  end

  // The whole latch is reloaded from pin levels merged with the new bits;
  // with only whole-byte strobes the merge keeps nothing of the old latch
  always_comb begin
    next_latch = pin_view[2:0];
    if (w_lane0) begin
      next_latch = w_byte[2:0];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      latch <= fbp_pkg::LATCH_RESET;
    end else if (wr_en[SEL_DATA]) begin
      latch <= next_latch;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dir_low <= fbp_pkg::DIR_RESET[2:0];
    end else if (wr_en[SEL_DIR]) begin
      dir_low <= w_byte[2:0];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ana_sel <= fbp_pkg::ANA_RESET;
    end else if (wr_en[SEL_ANA]) begin
      ana_sel <= w_byte[2:0] & LOWER_MASK;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      master_clear_enable_cfg <= fbp_pkg::MASTER_CLEAR_ENABLE_CFG_RESET;
    end else if (wr_en[SEL_CFG]) begin
      master_clear_enable_cfg <= w_byte[fbp_pkg::CFG_MASTER_CLEAR_ENABLE_CFG_BIT];
    end
  end

  // Read channel: one read in flight, answered the cycle after the address
  assign ARREADY_O = !RVALID_O;

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RVALID_O <= 1'b0;
      RDATA_O  <= 32'h00000000;
      RRESP_O  <= fbp_pkg::RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      RVALID_O <= 1'b1;
      RRESP_O  <= fbp_pkg::RESP_OKAY;
      case (ARADDR_I)
        fbp_pkg::OFF_PIN_DATA:   RDATA_O <= fbp_zext({4'h0, pin_view});
        fbp_pkg::OFF_DIRECTION:  RDATA_O <= fbp_zext({4'h0, dir_view});
        fbp_pkg::OFF_ANALOG_SEL: RDATA_O <= fbp_zext({5'h00, ana_sel});
        fbp_pkg::OFF_CONFIG:     RDATA_O <= fbp_zext({7'h00, master_clear_enable_cfg});
        default: begin
          RDATA_O <= 32'h00000000;
          RRESP_O <= fbp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (RREADY_I) begin
      RVALID_O <= 1'b0;
    end
  end
endmodule : fbp_port

// File: tb/fbp_port_properties.sv
// Port-level assertions for the four-bit port.
// Assumes it is bound to fbp_port and sees only its ports.
`timescale 1ns/1ps
module fbp_port_props (
  input wire logic        CLOCK_I,
  input wire logic        RST_N_I,
  input wire logic        ARVALID_I,
  input wire logic        ARREADY_O,
  input wire logic        RVALID_O,
  input wire logic        RREADY_I,
  input wire logic [31:0] RDATA_O,
  input wire logic        BVALID_O,
  input wire logic        BREADY_I,
  input wire logic        AWREADY_O,
  input wire logic        WREADY_O,
  input wire logic [2:0]  PIN_O,
  input wire logic [2:0]  PIN_OE_N_O,
  input wire logic        PIN3_PULLUP_EN_O,
  input wire logic        MASTER_CLEAR_N_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  AST_R_HOLD: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read data dropped early");
  AST_B_HOLD: assert property (BVALID_O && !BREADY_I |=> BVALID_O)
    else $error("write response dropped early");
  AST_AR_BLOCK: assert property (RVALID_O |-> !ARREADY_O)
    else $error("read accepted while answer pending");
  AST_AW_BLOCK: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
    else $error("write accepted while response pending");
  AST_R_NEXT: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("read answer late");
  AST_UPPER: assert property (RVALID_O |-> RDATA_O[31:4] == 28'h0)
    else $error("upper read bits not zero");
  // Drivers move only on a completed register write
  AST_DRV_CAUSE: assert property ($changed({PIN_O, PIN_OE_N_O}) |-> $rose(BVALID_O))
    else $error("pin driver changed without a write");
  AST_MCLR_OFF: assert property (!PIN3_PULLUP_EN_O |-> MASTER_CLEAR_N_O)
    else $error("master clear asserted while disabled");
endmodule : fbp_port_props

// File: tb/fbp_board.sv
// Board model: holds a level on every pin the port releases.
// Assumes active-low driver enables from the port.
`timescale 1ns/1ps
module fbp_board (
  input  wire logic [2:0] drv_i,
  input  wire logic [2:0] oe_n_i,
  input  wire logic [3:0] ext_i,
  output logic      [3:0] pad_o
);
  always_comb begin
    pad_o = ext_i;
    for (int k = 0; k < 3; k++) if (!oe_n_i[k]) pad_o[k] = drv_i[k];
  end
endmodule : fbp_board

// File: tb/testbench.sv
// Self-checking bench for the four-bit port over AXI4-Lite.
// Assumes fbp_board stands for the board on the pins.
`timescale 1ns/1ps
module testbench;
  logic        clk, rst_n, awv, wv, br, arv, rr, awr, wrd, bv, arr, rv, pup, mcn;
  logic [3:0]  aa, ra, ext, pad;
  logic [31:0] wd, rdat;
  logic [2:0]  po, oen;
  logic [1:0]  bresp, rresp;
  logic [3:0]  ws;
  int          bad_count, samples_checked, cyc;
  fbp_port fbp_port_inst (.CLOCK_I(clk), .RST_N_I(rst_n), .AWADDR_I(aa), .AWVALID_I(awv),
    .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(ws), .WVALID_I(wv), .WREADY_O(wrd),
    .BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(br), .ARADDR_I(ra), .ARVALID_I(arv),
    .ARREADY_O(arr), .RDATA_O(rdat), .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(rr),
    .PIN_I(pad), .PIN_O(po), .PIN_OE_N_O(oen), .PIN3_PULLUP_EN_O(pup),
    .MASTER_CLEAR_N_O(mcn));
  fbp_board fbp_board_inst (.drv_i(po), .oe_n_i(oen), .ext_i(ext), .pad_o(pad));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  function automatic logic [1:0] exp_resp(input logic [3:0] a);
    if (a == fbp_pkg::OFF_PIN_DATA || a == fbp_pkg::OFF_DIRECTION ||
        a == fbp_pkg::OFF_ANALOG_SEL || a == fbp_pkg::OFF_CONFIG)
      exp_resp = fbp_pkg::RESP_OKAY;
    else
      exp_resp = fbp_pkg::RESP_SLVERR;
  endfunction : exp_resp
  // Ready goes up only once the answer is offered, so every answer must stand
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    aa  <= a;
    wd  <= {24'h0, d};
    awv <= 1'b1;
    wv  <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv && !br) br <= 1'b1;
    end while (!(bv && br));
    br <= 1'b0;
    chk({30'h0, bresp}, {30'h0, exp_resp(a)});
  endtask : wr
  // Extra edges let pin levels through the two-flop sampler first
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    repeat (3) @(posedge clk);
    ra  <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv && !rr) rr <= 1'b1;
    end while (!(rv && rr));
    rr <= 1'b0;
    chk(rdat, {24'h0, e});
    chk({30'h0, rresp}, {30'h0, exp_resp(a)});
  endtask : rd
  task automatic conclude();
    $display("checked=%0d bad=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    {rst_n, awv, wv, br, arv, rr, aa, ra, wd} = '0;
    ext = 4'hF;
    ws  = 4'hF;
    {bad_count, samples_checked, cyc} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(fbp_pkg::OFF_DIRECTION, 8'h0F);
    rd(fbp_pkg::OFF_ANALOG_SEL, 8'h07);
    rd(fbp_pkg::OFF_PIN_DATA, 8'h00);
    rd(fbp_pkg::OFF_CONFIG, 8'h01);
    $display("test reset done");
    wr(fbp_pkg::OFF_CONFIG, 8'h00);
    wr(fbp_pkg::OFF_ANALOG_SEL, 8'h00);
    rd(fbp_pkg::OFF_PIN_DATA, 8'h0F);
    wr(fbp_pkg::OFF_DIRECTION, 8'hFF);
    rd(fbp_pkg::OFF_DIRECTION, 8'h0F);
    wr(fbp_pkg::OFF_DIRECTION, 8'h00);
    rd(fbp_pkg::OFF_DIRECTION, 8'h08);
    wr(fbp_pkg::OFF_PIN_DATA, 8'hFA);
    chk({29'h0, po}, 32'h2);
    chk({29'h0, oen}, 32'h0);
    rd(fbp_pkg::OFF_PIN_DATA, 8'h0A);
    $display("test digital done");
    wr(fbp_pkg::OFF_ANALOG_SEL, 8'hFF);
    rd(fbp_pkg::OFF_ANALOG_SEL, 8'h07);
    rd(fbp_pkg::OFF_PIN_DATA, 8'h08);
    chk({29'h0, oen}, 32'h0);
    wr(fbp_pkg::OFF_DIRECTION, 8'h0F);
    chk({29'h0, oen}, 32'h7);
    $display("test analog done");
    ws <= 4'h0;
    wr(fbp_pkg::OFF_DIRECTION, 8'h00);
    ws <= 4'hF;
    rd(fbp_pkg::OFF_DIRECTION, 8'h0F);
    wr(4'h2, 8'h00);
    rd(4'h2, 8'h00);
    chk({29'h0, oen}, 32'h7);
    $display("test errors done");
    wr(fbp_pkg::OFF_CONFIG, 8'h01);
    chk({31'h0, pup}, 32'h1);
    rd(fbp_pkg::OFF_PIN_DATA, 8'h00);
    ext <= 4'h7;
    repeat (4) @(posedge clk);
    chk({31'h0, mcn}, 32'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(fbp_pkg::OFF_ANALOG_SEL, 8'h07);
    $display("test clear done");
    conclude();
  end
endmodule : testbench
bind fbp_port fbp_port_props fbp_port_props_inst (.*);
